// ### timed_io_map.svh
`ifndef TIMED_IO_MAP_SVH
`define TIMED_IO_MAP_SVH

// ----------------------------------------------------------
// sizes and pin mapping
// ----------------------------------------------------------
`define NUM_PORTS       6
`define NUM_PINS        32
`define NUM_CLKBLK      6
`define PORT0_BASE      0
`define PORT0_WIDTH     1
`define PORT1_BASE      1
`define PORT1_WIDTH     1
`define PORT2_BASE      0
`define PORT2_WIDTH     4
`define PORT3_BASE      0
`define PORT3_WIDTH     8
`define PORT4_BASE      0
`define PORT4_WIDTH     16
`define PORT5_BASE      0
`define PORT5_WIDTH     32
`define LINK_PIN_LO     28
`define LINK_WIDTH      4

// ----------------------------------------------------------
// register byte offsets, per-port register indices and fields
// ----------------------------------------------------------
`define REG_PORT_END    8'h60
`define REG_CTRL        2'h0
`define REG_DATA        2'h1
`define REG_COND        2'h2
`define REG_TIME        2'h3
`define REG_CLKBLK_BASE 8'h60
`define REG_LINK        8'h78
`define CTRL_CFG_BITS   11
`define CTRL_FULL_BIT   12
`define CTRL_ARMED_BIT  13
`define CLK_SRC_LO      0
`define CLK_DIV_LO      8
`define RST_CLKSEL      3'h0

// ----------------------------------------------------------
// timing
// ----------------------------------------------------------
`define CORE_CLK_MHZ    9'd250
`define REF_CLK_MHZ     9'd100
`endif

// ### timed_io_pkg.sv
package timed_io_pkg;

    typedef enum logic [1:0] {COND_NONE, COND_EQ, COND_NE} condMode_type;
    typedef enum logic [1:0] {SRC_REF, SRC_PIN0, SRC_PIN1} clkSrc_type;

    // bit 0 is enable, bit 10 serialize
    typedef struct packed {
        logic         serialize;
        logic         strobeOut;
        logic         strobeIn;
        condMode_type condMode;
        logic [2:0]   clkSel;
        logic         openDrain;
        logic         outDir;
        logic         en;
    } portCfg_type;

    typedef struct packed {
        portCfg_type cfg;
        logic [31:0] condVal;
        logic [15:0] count;
        logic [15:0] timeAt;
        logic [15:0] stamp;
        logic        timedArm;
        logic [31:0] xfer;
        logic        full;
        logic [31:0] shift;
        logic [5:0]  shiftCnt;
        logic        strobeOut;
        logic        evt;
    } port_type;

    typedef struct packed {
        clkSrc_type src;
        logic [7:0] div;
        logic [7:0] divCnt;
        logic       srcPrev;
        logic       tick;
    } clkBlk_type;

endpackage

// ### timed_io_port_unit.sv
`timescale 1ns/1ps
`default_nettype none
`include "timed_io_map.svh"

module timed_io_port_unit
    import timed_io_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        rst,
    input  wire logic [7:0]  address,
    input  wire logic        read,
    input  wire logic        write,
    input  wire logic [31:0] writedata,
    input  wire logic [3:0]  byteenable,
    output logic      [31:0] readdata,
    output logic             waitrequest,
    input  wire logic [31:0] pinIn,
    output logic      [31:0] pinOut,
    output logic      [31:0] pinOeN,
    input  wire logic [5:0]  inputStrobe,
    output logic      [5:0]  outputStrobe,
    output logic      [5:0]  portEvent,
    input  wire logic [3:0]  linkTxData,
    input  wire logic [3:0]  linkTxOe,
    output logic      [3:0]  linkRxData
);

    // ----------------------------------------------------------
    // state
    // ----------------------------------------------------------
    typedef struct packed {
        port_type   [`NUM_PORTS-1:0]  port;
        clkBlk_type [`NUM_CLKBLK-1:0] blk;
        logic [7:0]  refAcc;
        logic        refTick;
        logic        linkEn;
        logic [31:0] pinSync1;
        logic [31:0] pinSync2;
        logic [5:0]  stbSync1;
        logic [5:0]  stbSync2;
        logic [31:0] pinOut;
        logic [31:0] pinOeN;
        logic [3:0]  linkRx;
        logic        waitReq;
        logic [31:0] rdata;
    } state_type;

    state_type s;
    state_type next_s;

    // ----------------------------------------------------------
    // decoding helpers
    // ----------------------------------------------------------
    function automatic int portBase(input int p);
        case (p)
            0:       portBase = `PORT0_BASE;
            1:       portBase = `PORT1_BASE;
            2:       portBase = `PORT2_BASE;
            3:       portBase = `PORT3_BASE;
            4:       portBase = `PORT4_BASE;
            default: portBase = `PORT5_BASE;
        endcase
    endfunction

    // ports are ordered narrowest first, which the pin arbiter uses
    function automatic int portWidth(input int p);
        case (p)
            0:       portWidth = `PORT0_WIDTH;
            1:       portWidth = `PORT1_WIDTH;
            2:       portWidth = `PORT2_WIDTH;
            3:       portWidth = `PORT3_WIDTH;
            4:       portWidth = `PORT4_WIDTH;
            default: portWidth = `PORT5_WIDTH;
        endcase
    endfunction

    function automatic logic [31:0] portMask(input int p);
        if (portWidth(p) >= `NUM_PINS) begin
            portMask = '1;
        end else begin
            portMask = (32'h1 << portWidth(p)) - 32'h1;
        end
    endfunction

    // number of pin samples that fill one 32-bit transfer word
    function automatic logic [5:0] portSlots(input int p);
        portSlots = 6'(`NUM_PINS / portWidth(p));
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0]  be);
        merge = old;
        for (int k = 0; k < 4; k++) begin
            if (be[k]) begin
                merge[8*k +: 8] = wd[8*k +: 8];
            end
        end
    endfunction

    // ----------------------------------------------------------
    // next state
    // ----------------------------------------------------------
    always_comb begin
        logic [8:0]  acc;
        logic        srcLvl;
        logic        raw;
        logic        tk;
        logic        qual;
        logic        condOk;
        logic        timeOk;
        logic        found;
        logic [31:0] sample;
        logic [31:0] tmp;
        logic [31:0] rd;
        logic [31:0] wd;
        logic [7:0]  off;
        logic [5:0]  dataWr;
        int          p;
        int          r;
        int          b;
        int          w;
        acc    = '0;
        srcLvl = 1'b0;
        raw    = 1'b0;
        tk     = 1'b0;
        qual   = 1'b0;
        condOk = 1'b0;
        timeOk = 1'b0;
        found  = 1'b0;
        sample = '0;
        tmp    = '0;
        rd     = '0;
        wd     = '0;
        off    = '0;
        dataWr = '0;
        p      = 0;
        r      = 0;
        b      = 0;
        w      = 1;
        next_s = s;

        // two-stage synchronisers for pins and strobes
        next_s.pinSync1 = pinIn;
        next_s.pinSync2 = s.pinSync1;
        next_s.stbSync1 = inputStrobe;
        next_s.stbSync2 = s.stbSync1;

        // fractional accumulator: average tick rate is the reference rate
        acc = 9'(s.refAcc) + `REF_CLK_MHZ;
        next_s.refTick = 1'b0;
        if (acc >= `CORE_CLK_MHZ) begin
            acc = acc - `CORE_CLK_MHZ;
            next_s.refTick = 1'b1;
        end
        next_s.refAcc = acc[7:0];

        // clock blocks; block 0 is fixed to the reference
        for (int k = 0; k < `NUM_CLKBLK; k++) begin
            srcLvl = 1'b0;
            if (s.blk[k].src == SRC_PIN0) begin
                srcLvl = s.pinSync2[`PORT0_BASE];
            end else if (s.blk[k].src == SRC_PIN1) begin
                srcLvl = s.pinSync2[`PORT1_BASE];
            end
            raw = (s.blk[k].src == SRC_REF) ? s.refTick
                                            : (srcLvl & ~s.blk[k].srcPrev);
            next_s.blk[k].srcPrev = srcLvl;
            next_s.blk[k].tick    = 1'b0;
            if (k == 0) begin
                next_s.blk[k].tick = s.refTick;
            end else if (raw) begin
                // divide by div+1; div of zero passes every edge
                if (s.blk[k].divCnt >= s.blk[k].div) begin
                    next_s.blk[k].divCnt = '0;
                    next_s.blk[k].tick   = 1'b1;
                end else begin
                    next_s.blk[k].divCnt = s.blk[k].divCnt + 8'h1;
                end
            end
        end

        // avalon slave: waitrequest drops one cycle after the request
        next_s.waitReq = 1'b1;
        if ((read || write) && s.waitReq) begin
            next_s.waitReq = 1'b0;
            if (address < `REG_PORT_END) begin
                p = int'(address[7:4]);
                r = int'(address[3:2]);
                case (r)
                    `REG_CTRL: begin
                        rd[`CTRL_CFG_BITS-1:0] = s.port[p].cfg;
                        rd[`CTRL_FULL_BIT]     = s.port[p].full;
                        rd[`CTRL_ARMED_BIT]    = s.port[p].timedArm;
                        wd = merge(rd, writedata, byteenable);
                        if (write) begin
                            // one direction bit covers every pin of a port
                            next_s.port[p].cfg =
                                portCfg_type'(wd[`CTRL_CFG_BITS-1:0]);
                        end
                    end
                    `REG_DATA: begin
                        rd = s.port[p].xfer;
                        if (read && !s.port[p].cfg.outDir) begin
                            next_s.port[p].full = 1'b0;
                        end
                        if (write) begin
                            next_s.port[p].xfer =
                                merge(s.port[p].xfer, writedata, byteenable);
                            next_s.port[p].full = 1'b1;
                            dataWr[p] = 1'b1;
                        end
                    end
                    `REG_COND: begin
                        rd = s.port[p].condVal;
                        if (write) begin
                            next_s.port[p].condVal = merge(rd, writedata,
                                                           byteenable);
                        end
                    end
                    default: begin
                        // live counter and last timestamp
                        rd = {s.port[p].stamp, s.port[p].count};
                        wd = merge(32'h0, writedata, byteenable);
                        if (write) begin
                            next_s.port[p].timeAt   = wd[15:0];
                            next_s.port[p].timedArm = 1'b1;
                        end
                    end
                endcase
            end else if (address == `REG_LINK) begin
                rd[0] = s.linkEn;
                if (write && byteenable[0]) begin
                    next_s.linkEn = writedata[0];
                end
            end else begin
                off = address - `REG_CLKBLK_BASE;
                b   = int'(off[7:2]);
                if (b < `NUM_CLKBLK) begin
                    rd[`CLK_SRC_LO +: 2] = s.blk[b].src;
                    rd[`CLK_DIV_LO +: 8] = s.blk[b].div;
                    wd = merge(rd, writedata, byteenable);
                    // block 0 cannot be reprogrammed
                    if (write && b != 0) begin
                        next_s.blk[b].src =
                            clkSrc_type'(wd[`CLK_SRC_LO +: 2]);
                        next_s.blk[b].div = wd[`CLK_DIV_LO +: 8];
                    end
                end
            end
            next_s.rdata = rd;
        end

        // ports; hardware updates come after the bus so a set of full wins
        for (int k = 0; k < `NUM_PORTS; k++) begin
            w  = portWidth(k);
            tk = (s.port[k].cfg.clkSel < 3'(`NUM_CLKBLK))
                 ? s.blk[s.port[k].cfg.clkSel].tick : 1'b0;
            timeOk = !s.port[k].timedArm ||
                     (s.port[k].count == s.port[k].timeAt);
            next_s.port[k].evt = 1'b0;
            if (!s.port[k].cfg.en) begin
                next_s.port[k].strobeOut = 1'b0;
            end else if (tk) begin
                next_s.port[k].count = s.port[k].count + 16'h1;
                if (!s.port[k].cfg.outDir) begin
                    // input: full width sampled even if pins are lent out
                    sample = (s.pinSync2 >> portBase(k)) & portMask(k);
                    qual = !s.port[k].cfg.strobeIn || s.stbSync2[k];
                    case (s.port[k].cfg.condMode)
                        COND_EQ: condOk = sample ==
                                 (s.port[k].condVal & portMask(k));
                        COND_NE: condOk = sample !=
                                 (s.port[k].condVal & portMask(k));
                        default: condOk = 1'b1;
                    endcase
                    if (qual && condOk && timeOk) begin
                        tmp = s.port[k].cfg.serialize
                              ? ((s.port[k].shift >> w) |
                                 (sample << (`NUM_PINS - w)))
                              : sample;
                        next_s.port[k].shift = tmp;
                        if (!s.port[k].cfg.serialize ||
                            s.port[k].shiftCnt + 6'h1 == portSlots(k)) begin
                            next_s.port[k].xfer     = tmp;
                            next_s.port[k].full     = 1'b1;
                            next_s.port[k].stamp    = s.port[k].count;
                            next_s.port[k].timedArm = 1'b0;
                            next_s.port[k].shiftCnt = '0;
                            next_s.port[k].evt      = 1'b1;
                        end else begin
                            next_s.port[k].shiftCnt = s.port[k].shiftCnt + 6'h1;
                        end
                    end
                end else begin
                    // output: shift out remaining slots, then reload
                    next_s.port[k].strobeOut = 1'b0;
                    if (s.port[k].shiftCnt > 6'h1) begin
                        next_s.port[k].shift    = s.port[k].shift >> w;
                        next_s.port[k].shiftCnt = s.port[k].shiftCnt - 6'h1;
                        next_s.port[k].strobeOut = s.port[k].cfg.strobeOut;
                    end else if (s.port[k].full && timeOk && !dataWr[k]) begin
                        // a word written this cycle is kept for the next tick
                        next_s.port[k].shift    = s.port[k].xfer;
                        next_s.port[k].full     = 1'b0;
                        next_s.port[k].shiftCnt = s.port[k].cfg.serialize
                                                  ? portSlots(k) : 6'h1;
                        next_s.port[k].stamp    = s.port[k].count;
                        next_s.port[k].timedArm = 1'b0;
                        next_s.port[k].evt      = 1'b1;
                        next_s.port[k].strobeOut = s.port[k].cfg.strobeOut;
                    end else begin
                        next_s.port[k].shiftCnt = '0;
                    end
                end
            end
        end

        // pin arbiter: link first, then the narrowest enabled port
        for (int i = 0; i < `NUM_PINS; i++) begin
            next_s.pinOut[i] = 1'b0;
            next_s.pinOeN[i] = 1'b1;
            found = 1'b0;
            if (s.linkEn && i >= `LINK_PIN_LO &&
                i < `LINK_PIN_LO + `LINK_WIDTH) begin
                next_s.pinOut[i] = linkTxData[i - `LINK_PIN_LO];
                next_s.pinOeN[i] = ~linkTxOe[i - `LINK_PIN_LO];
            end else begin
                for (int o = 0; o < `NUM_PORTS; o++) begin
                    if (!found && s.port[o].cfg.en && i >= portBase(o) &&
                        i < portBase(o) + portWidth(o)) begin
                        found = 1'b1;
                        if (s.port[o].cfg.outDir) begin
                            tmp = s.port[o].shift >> (i - portBase(o));
                            if (s.port[o].cfg.openDrain) begin
                                next_s.pinOeN[i] = tmp[0];
                            end else begin
                                next_s.pinOut[i] = tmp[0];
                                next_s.pinOeN[i] = 1'b0;
                            end
                        end
                    end
                end
            end
        end
        next_s.linkRx = s.pinSync2[`LINK_PIN_LO +: `LINK_WIDTH];
    end

    // ----------------------------------------------------------
    // registers
    // ----------------------------------------------------------
    // zero reset leaves every port disabled on clock block 0
    always_ff @(posedge core_clk) begin
        if (rst) begin
            s         <= '0;
            s.waitReq <= 1'b1;
            s.pinOeN  <= '1;
            for (int k = 0; k < `NUM_PORTS; k++) begin
                s.port[k].cfg.clkSel <= `RST_CLKSEL;
            end
        end else begin
            s <= next_s;
        end
    end

    // ----------------------------------------------------------
    // outputs, all straight from flops
    // ----------------------------------------------------------
    assign readdata    = s.rdata;
    assign waitrequest = s.waitReq;
    assign pinOut      = s.pinOut;
    assign pinOeN      = s.pinOeN;
    assign linkRxData  = s.linkRx;

    for (genvar g = 0; g < `NUM_PORTS; g++) begin : gen_port_out
        assign outputStrobe[g] = s.port[g].strobeOut;
        assign portEvent[g]    = s.port[g].evt;
    end

endmodule

`default_nettype wire

// ### timed_io_port_unit_properties.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------
// bus handshake and reset checks at the unit's ports
// ----------------------------------------------------------
module timed_io_port_unit_properties (
    input wire logic        core_clk,
    input wire logic        rst,
    input wire logic [7:0]  address,
    input wire logic        read,
    input wire logic        write,
    input wire logic [31:0] readdata,
    input wire logic        waitrequest,
    input wire logic [31:0] pinOeN,
    input wire logic [5:0]  outputStrobe,
    input wire logic [5:0]  portEvent
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    // reset checks stay live while rst is high
    property p_resetBus;
        disable iff (1'b0) rst |=> waitrequest && readdata == 32'h0;
    endproperty
    a_resetBus: assert property (p_resetBus) else $error("bus not idle after reset");
    property p_resetPins;
        disable iff (1'b0)
        rst |=> pinOeN == 32'hffffffff && portEvent == 6'h0 && outputStrobe == 6'h0;
    endproperty
    a_resetPins: assert property (p_resetPins) else $error("pins driven after reset");
    property p_answer;
        (read || write) && waitrequest |=> !waitrequest;
    endproperty
    a_answer: assert property (p_answer) else $error("access not answered in one cycle");
    property p_waitOne;
        !waitrequest |=> waitrequest;
    endproperty
    a_waitOne: assert property (p_waitOne) else $error("waitrequest low too long");
    property p_noSpont;
        !waitrequest |-> $past(read) || $past(write);
    endproperty
    a_noSpont: assert property (p_noSpont) else $error("answer without request");
    property p_idle;
        !(read || write) && waitrequest |=> waitrequest;
    endproperty
    a_idle: assert property (p_idle) else $error("answer while idle");
    property p_rdHold;
        waitrequest && $past(waitrequest) |-> $stable(readdata);
    endproperty
    a_rdHold: assert property (p_rdHold) else $error("readdata moved between accesses");
    // a hole in the map must read as zero
    property p_unmapped;
        read && waitrequest && address == 8'h7c |=> readdata == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    c_write: cover property (write && !waitrequest);
    c_read: cover property (read && !waitrequest);
    c_event: cover property (portEvent != 6'h0);
endmodule
`default_nettype wire

// ### pin_partner.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------
// application hardware on the pins
// ----------------------------------------------------------
module pin_partner (
    input  wire logic [31:0] pinOut,
    input  wire logic [31:0] pinOeN,
    input  wire logic [31:0] drive,
    input  wire logic        strobe,
    output logic      [31:0] pinIn,
    output logic      [5:0]  inputStrobe
);
    // the device's value wins where it drives; elsewhere our own value shows
    always_comb begin
        for (int k = 0; k < 32; k++) begin
            pinIn[k] = !pinOeN[k] ? pinOut[k] : drive[k];
        end
    end
    // strobe raised only once the data is already steady
    assign inputStrobe = {6{strobe}};
endmodule
`default_nettype wire

// ### test_timed_io_port_unit.sv
`timescale 1ns/1ps
`default_nettype none
module test_timed_io_port_unit
    import timed_io_pkg::*;
;
    logic        core_clk = 1'b0, rst = 1'b1, read = 1'b0, write = 1'b0;
    logic        strobe = 1'b0;
    logic [7:0]  address = 8'h00;
    logic [31:0] writedata = 32'h0, drive = 32'h0, q, d, t;
    logic [3:0]  byteenable = 4'hf, linkTxData = 4'h0, linkTxOe = 4'h0;
    logic [31:0] readdata, pinIn, pinOut, pinOeN;
    logic [5:0]  inputStrobe, outputStrobe, portEvent;
    logic [3:0]  linkRxData;
    logic        waitrequest;
    int          fail_count = 0, check_count = 0, cycles = 0, seed = 14, n;
    always #2 core_clk = ~core_clk;
    timed_io_port_unit uut (.core_clk(core_clk), .rst(rst), .address(address),
        .read(read), .write(write), .writedata(writedata),
        .byteenable(byteenable), .readdata(readdata),
        .waitrequest(waitrequest), .pinIn(pinIn), .pinOut(pinOut),
        .pinOeN(pinOeN), .inputStrobe(inputStrobe),
        .outputStrobe(outputStrobe), .portEvent(portEvent),
        .linkTxData(linkTxData), .linkTxOe(linkTxOe),
        .linkRxData(linkRxData));
    pin_partner far (.pinOut(pinOut), .pinOeN(pinOeN), .drive(drive),
        .strobe(strobe), .pinIn(pinIn), .inputStrobe(inputStrobe));
    // ------------------------------------------------------
    // tasks
    // ------------------------------------------------------
    task automatic results();
        if (fail_count == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic check(input string name, input logic [31:0] seen, exp);
        check_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // request held until the edge that sees waitrequest low
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] wd, output logic [31:0] rd);
        @(posedge core_clk);
        address <= a;
        write <= w;
        read <= !w;
        writedata <= wd;
        @(posedge core_clk iff waitrequest === 1'b0);
        rd = readdata;
        read <= 1'b0;
        write <= 1'b0;
    endtask
    // pins settle one cycle after the transfer pulse
    task automatic waitEvt(input int p);
        for (n = 0; n < 400 && portEvent[p] !== 1'b1; n++) @(negedge core_clk);
        check("portEvent", n < 400, 1);
        @(negedge core_clk);
    endtask
    // a hang counts as a mismatch
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            results();
        end
    end
    // ------------------------------------------------------
    // scenarios
    // ------------------------------------------------------
    initial begin
        repeat (5) @(posedge core_clk);
        rst <= 1'b0;
        @(negedge core_clk);
        check("waitrequest", waitrequest, 1);
        check("pinOeN", pinOeN, 32'hffffffff);
        // single-bit output, then its counter must move
        bus(1, 8'h00, 32'h3, q);
        bus(1, 8'h04, 32'h1, q);
        waitEvt(0);
        check("pin0", {pinOeN[0], pinOut[0]}, 2'b01);
        bus(0, 8'h0c, 0, t);
        bus(0, 8'h0c, 0, q);
        check("counter", q[15:0] !== t[15:0], 1);
        // byte port under the bit port: pin 0 stays with port 0
        d = $random(seed) & 32'hfe;
        bus(1, 8'h30, 32'h3, q);
        bus(1, 8'h34, d, q);
        waitEvt(3);
        check("byte pins", pinOut[7:0], d[7:0] | 8'h01);
        // open-drain half-word: only its free upper byte is seen
        d = $random(seed);
        bus(1, 8'h40, 32'h7, q);
        bus(1, 8'h44, d, q);
        waitEvt(4);
        check("od enable", pinOeN[15:8], d[15:8]);
        check("od level", pinOut[15:8], 8'h00);
        check("push-pull", pinOeN[7:0], 8'h00);
        // strobed word input: nothing taken until the strobe rises
        for (int p = 0; p < 5; p++) bus(1, 8'(p * 16), 32'h0, q);
        bus(1, 8'h50, 32'h101, q);
        drive <= $random(seed);
        t = 0;
        repeat (60) begin
            @(negedge core_clk);
            t = t | portEvent[5];
        end
        check("no strobe", t, 0);
        check("input dir", pinOeN, 32'hffffffff);
        @(posedge core_clk);
        strobe <= 1'b1;
        waitEvt(5);
        bus(0, 8'h54, 0, q);
        check("input word", q, drive);
        // link takes its pins from the input port
        d = $random(seed);
        linkTxData <= d[3:0];
        linkTxOe <= 4'hf;
        bus(1, 8'h78, 32'h1, q);
        repeat (6) @(negedge core_clk);
        check("link pins", {pinOeN[31:28], pinOut[31:28]}, {4'h0, d[3:0]});
        check("link rx", linkRxData, d[3:0]);
        // clock blocks: block 0 fixed, others settable; map hole
        d = $random(seed) & 32'hff02;
        bus(1, 8'h64, d, q);
        bus(0, 8'h64, 0, q);
        check("clock block 1", q, d);
        bus(1, 8'h60, d, q);
        bus(0, 8'h60, 0, q);
        check("clock block 0", q, 32'h0);
        bus(1, 8'h7c, d, q);
        bus(0, 8'h7c, 0, q);
        check("unmapped", q, 32'h0);
        // serialized nibble output with strobe, held back to a counter value
        d = $random(seed);
        bus(1, 8'h20, 32'h603, q);
        bus(0, 8'h2c, 0, t);
        t[15:0] = t[15:0] + 16'd40;
        bus(1, 8'h2c, t, q);
        bus(1, 8'h24, d, q);
        waitEvt(2);
        check("slot 0", pinOut[3:0], d[3:0]);
        check("strobe out", outputStrobe[2], 1);
        // reference ticks alternate gaps of two and three cycles
        repeat (4) @(negedge core_clk);
        check("slot 1", pinOut[3:0], d[7:4]);
        bus(0, 8'h2c, 0, q);
        check("timestamp", q[31:16], t[15:0]);
        // word input under a compare that cannot match, then its inverse
        bus(1, 8'h58, ~drive, q);
        bus(1, 8'h50, 32'h41, q);
        t = 0;
        repeat (40) begin
            @(negedge core_clk);
            t = t | portEvent[5];
        end
        check("cond equal", t, 0);
        bus(1, 8'h50, 32'h81, q);
        waitEvt(5);
        results();
    end
endmodule
bind timed_io_port_unit timed_io_port_unit_properties chk (.core_clk,
    .rst, .address, .read, .write, .readdata, .waitrequest, .pinOeN,
    .outputStrobe, .portEvent);
`default_nettype wire
